// ### rtl/debug_emu_pkg.sv
//==============================================================
// Operation
// RULE_01: Breakpoint trigger response selectable: show only, halt for debug, debug interrupt.
// RULE_02: Trigger state always shown on the status/debug data bus.
// RULE_03: Debug interrupt outranks every normal interrupt request level.
// RULE_04: Optionally steer fetches and data inside the debug routine to separate space.
// RULE_05: Interrupt mask level stays unchanged when a debug interrupt is taken.
// RULE_06: Debug interrupt entry drives status code 0xD for several cycles.
// RULE_07: Debug interrupt sets the hidden emulator-mode bit; software cannot read it.
// RULE_08: Inside the debug routine, normal interrupts are sampled once per instruction.
// RULE_09: New exception captures the emulator-mode bit, then clears it before the handler.
// RULE_10: Captured bit goes to fault status bit 1, frame longword bit 17.
// RULE_11: Exception return reloads the saved flag; one re-enters emulator mode.
// RULE_12: Resuming the debug routine after exception return drives status code 0xD again.
// RULE_13: Unlimited nesting, saving and restoring the emulator bit per exception level.
package debug_emu_pkg;

	//==============================================================
	// Widths and encodings
	localparam int        STATUS_WIDTH      = 4;
	localparam int        TRIG_STATE_WIDTH  = 4;
	localparam int        LEVEL_WIDTH       = 3;
	localparam int        FRAME_WIDTH       = 32;
	localparam logic [3:0] STATUS_DEBUG_INT = 4'hD;
	localparam logic [2:0] LEVEL_NONMASK    = 3'h7;

	//==============================================================
	// Frame layout: fault status field starts at bit 16
	localparam int FAULT_FIELD_LSB  = 16;
	localparam int FAULT_EMU_BIT    = 1;
	localparam int FRAME_EMU_BIT    = FAULT_FIELD_LSB + FAULT_EMU_BIT;

	//==============================================================
	// Counts and reset values
	localparam int          DEBUG_STATUS_CYCLES = 3;
	localparam logic [31:0] FRAME_RESET         = 32'h0000_0000;

	//==============================================================
	// Trigger response selection
	typedef enum logic [1:0] {
		RESP_SHOW_ONLY,
		RESP_HALT,
		RESP_DEBUG_INT,
		RESP_SPARE
	} resp_type;

endpackage

// ### rtl/level_sync.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("level_sync: WIDTH must be at least 1");
		end
	endgenerate

	//==============================================================
	// Two stages; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ### rtl/status_code_driver.sv
`timescale 1ns/100ps
`default_nettype none
module status_code_driver #(
	parameter int HOLD_CYCLES = debug_emu_pkg::DEBUG_STATUS_CYCLES
) (
	input  wire logic                                   clk,
	input  wire logic                                   rst_b,
	input  wire logic                                   start,
	input  wire logic [debug_emu_pkg::STATUS_WIDTH-1:0] core_code,
	output var  logic [debug_emu_pkg::STATUS_WIDTH-1:0] code_q
);
	import debug_emu_pkg::*;

	generate
		if (HOLD_CYCLES < 2 || HOLD_CYCLES > 15) begin : g_bad
			$error("status_code_driver: HOLD_CYCLES must be 2..15");
		end
	endgenerate

	localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES - 1);

	logic [3:0] left_q;
	logic [3:0] left_d;
	logic       holding;

	//==============================================================
	// Hold counter; a restart during a hold reloads it
	assign holding = start || (left_q != 4'h0);
	assign left_d  = start ? HOLD_LAST : (left_q != 4'h0) ? left_q - 4'h1 : 4'h0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			left_q <= 4'h0;
			code_q <= '0;
		end else begin
			left_q <= left_d;
			// RULE_06: debug code held
			code_q <= holding ? STATUS_DEBUG_INT : core_code;
		end
	end

endmodule
`default_nettype wire

// ### rtl/debug_interrupt_emulator_mode.sv
`timescale 1ns/100ps
`default_nettype none
module debug_interrupt_emulator_mode (
	input  wire logic                                      clk,
	input  wire logic                                      rst_b,
	input  wire logic                                      brk_trigger,
	input  wire logic [debug_emu_pkg::TRIG_STATE_WIDTH-1:0] brk_trigger_state,
	input  wire debug_emu_pkg::resp_type                   trigger_response,
	input  wire logic                                      alt_space_enable,
	input  wire logic [debug_emu_pkg::LEVEL_WIDTH-1:0]      irq_level_pin,
	input  wire logic [debug_emu_pkg::LEVEL_WIDTH-1:0]      mask_level,
	input  wire logic                                      instr_done,
	input  wire logic                                      exc_req,
	input  wire logic                                      rte_exec,
	input  wire logic [debug_emu_pkg::FRAME_WIDTH-1:0]      rte_frame_word,
	input  wire logic [debug_emu_pkg::STATUS_WIDTH-1:0]     core_status_code,
	input  wire logic                                      halt_release,
	output var  logic [debug_emu_pkg::STATUS_WIDTH-1:0]     processor_status_code,
	output var  logic [debug_emu_pkg::TRIG_STATE_WIDTH-1:0] processor_status_debug_bus,
	output var  logic                                      halted_background_debug,
	output var  logic                                      debug_int_taken,
	output var  logic                                      irq_taken,
	output var  logic [debug_emu_pkg::LEVEL_WIDTH-1:0]      irq_taken_level,
	output var  logic                                      mask_update,
	output var  logic                                      frame_write,
	output var  logic [debug_emu_pkg::FRAME_WIDTH-1:0]      exc_frame_word,
	output var  logic                                      alt_space_select
);
	import debug_emu_pkg::*;

	typedef enum logic {
		MODE_NORMAL,
		MODE_EMULATOR
	} mode_type;

	mode_type                    mode_q;
	mode_type                    mode_d;
	logic                        dbg_pend_q;
	logic                        dbg_pend_d;
	logic                        halt_q;
	logic                        halt_d;
	logic [TRIG_STATE_WIDTH-1:0] dbg_bus_q;
	logic                        dbg_taken_q;
	logic                        irq_taken_q;
	logic [LEVEL_WIDTH-1:0]      irq_lvl_q;
	logic                        mask_upd_q;
	logic                        frame_wr_q;
	logic [FRAME_WIDTH-1:0]      frame_q;
	logic [FRAME_WIDTH-1:0]      frame_d;
	logic                        alt_q;
	logic [LEVEL_WIDTH-1:0]      irq_level_s;

	logic emu_now;
	logic trig_debug;
	logic irq_valid;
	logic take_debug;
	logic take_exc;
	logic take_irq;
	logic take_any_exc;
	logic rte_resume;
	logic status_start;

	//==============================================================
	// Interrupt priority pins come from outside the clock domain
	level_sync #(
		.WIDTH (LEVEL_WIDTH)
	) u_irq_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in (irq_level_pin),
		.sync_out (irq_level_s)
	);

	// Level 7 passes any mask; others must exceed it
	function automatic logic level_wins(input logic [LEVEL_WIDTH-1:0] lvl,
	                                     input logic [LEVEL_WIDTH-1:0] mask);
		level_wins = (lvl == LEVEL_NONMASK) || (lvl > mask);
	endfunction

	//==============================================================
	// Event decode
	assign emu_now    = (mode_q == MODE_EMULATOR);
	// RULE_01: interrupt response selected
	assign trig_debug = brk_trigger && (trigger_response == RESP_DEBUG_INT);
	assign irq_valid  = (irq_level_s != 3'h0) && level_wins(irq_level_s, mask_level);
	// Return processing owns the cycle; sampling waits for the next boundary
	// RULE_03: debug outranks normal levels
	assign take_debug = instr_done && !rte_exec && dbg_pend_q && !emu_now;
	assign take_exc   = instr_done && !rte_exec && !take_debug && exc_req;
	// RULE_08: one sample per instruction
	assign take_irq   = instr_done && !rte_exec && !take_debug && !exc_req && irq_valid;
	assign take_any_exc = take_exc || take_irq;
	// RULE_11: saved flag decides resume
	assign rte_resume   = rte_exec && rte_frame_word[FRAME_EMU_BIT];
	assign status_start = take_debug || rte_resume;

	//==============================================================
	// Pending debug request; a new trigger wins over the take
	assign dbg_pend_d = trig_debug || (dbg_pend_q && !take_debug);

	//==============================================================
	// Halt request; a new trigger wins over the release
	// RULE_01: halt response selected
	assign halt_d = (brk_trigger && (trigger_response == RESP_HALT)) || (halt_q && !halt_release);

	//==============================================================
	// Emulator-mode state, never exposed on a port
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			MODE_NORMAL: begin
				// RULE_07: entry sets emulator mode
				if (take_debug) begin
					mode_d = MODE_EMULATOR;
				// RULE_11: reload from frame
				end else if (rte_resume) begin
					mode_d = MODE_EMULATOR;
				end
			end
			MODE_EMULATOR: begin
				// RULE_09: clear after capture
				if (take_any_exc) begin
					mode_d = MODE_NORMAL;
				end else if (rte_exec && !rte_resume) begin
					mode_d = MODE_NORMAL;
				end
			end
		endcase
	end

	//==============================================================
	// Frame word carries the captured bit in the fault field
	// RULE_10: captured bit to bit 17
	always_comb begin
		frame_d = FRAME_RESET;
		frame_d[FRAME_EMU_BIT] = emu_now;
	end

	//==============================================================
	// State registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q     <= MODE_NORMAL;
			dbg_pend_q <= 1'b0;
			halt_q     <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			dbg_pend_q <= dbg_pend_d;
			halt_q     <= halt_d;
		end
	end

	//==============================================================
	// Exception outputs; one-cycle pulses plus held frame word
	// RULE_13: per-level save and restore
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dbg_taken_q <= 1'b0;
			irq_taken_q <= 1'b0;
			irq_lvl_q   <= '0;
			mask_upd_q  <= 1'b0;
			frame_wr_q  <= 1'b0;
			frame_q     <= FRAME_RESET;
		end else begin
			dbg_taken_q <= take_debug;
			irq_taken_q <= take_irq;
			// RULE_05: mask untouched on debug
			mask_upd_q  <= take_irq;
			frame_wr_q  <= take_any_exc;
			if (take_irq) begin
				irq_lvl_q <= irq_level_s;
			end
			if (take_any_exc) begin
				frame_q <= frame_d;
			end
		end
	end

	//==============================================================
	// Trigger state always mirrored; alternate space follows emulator mode
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dbg_bus_q <= '0;
			alt_q     <= 1'b0;
		end else begin
			// RULE_02: trigger state always shown
			dbg_bus_q <= brk_trigger_state;
			// RULE_04: optional separate space
			alt_q     <= alt_space_enable && (mode_d == MODE_EMULATOR);
		end
	end

	//==============================================================
	// Status code, forced to debug code on entry and resume
	// RULE_12: resume shows debug code
	status_code_driver #(
		.HOLD_CYCLES (DEBUG_STATUS_CYCLES)
	) u_status (
		.clk       (clk),
		.rst_b     (rst_b),
		.start     (status_start),
		.core_code (core_status_code),
		.code_q    (processor_status_code)
	);

	assign processor_status_debug_bus = dbg_bus_q;
	assign halted_background_debug    = halt_q;
	assign debug_int_taken            = dbg_taken_q;
	assign irq_taken                  = irq_taken_q;
	assign irq_taken_level            = irq_lvl_q;
	assign mask_update                = mask_upd_q;
	assign frame_write                = frame_wr_q;
	assign exc_frame_word             = frame_q;
	assign alt_space_select           = alt_q;

	//==============================================================
	// Checks
	// RULE_06: debug code on entry
	entry_code_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
		take_debug |=> (processor_status_code == STATUS_DEBUG_INT) [*3])
		else $error("debug entry did not hold status code");

	// RULE_12: debug code on resume
	resume_code_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_12
		rte_resume |=> ##1 processor_status_code == STATUS_DEBUG_INT)
		else $error("resume did not show debug status code");

	// RULE_07: entry sets the mode
	emu_set_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
		take_debug |=> emu_now)
		else $error("emulator mode not set on debug entry");

	// RULE_09: capture then clear
	emu_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
		(take_any_exc && emu_now) |=> !emu_now && frame_write)
		else $error("emulator mode not cleared on exception");

	// RULE_10: frame bit carries old mode
	frame_bit_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		take_any_exc |=> exc_frame_word[17] == $past(emu_now))
		else $error("frame bit 17 does not match captured mode");

	// RULE_11: reload follows the flag
	rte_reload_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		rte_exec |=> emu_now == $past(rte_frame_word[17]))
		else $error("return did not reload emulator mode");

	// RULE_03: debug wins over interrupts
	debug_prio_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		(take_debug && irq_valid) |=> debug_int_taken && !irq_taken)
		else $error("normal interrupt beat debug interrupt");

	// RULE_05: no mask change on debug
	mask_keep_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		take_debug |=> !mask_update)
		else $error("mask updated on debug interrupt");

	// RULE_02: bus mirrors trigger state
	bus_mirror_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
		##1 processor_status_debug_bus == $past(brk_trigger_state))
		else $error("debug bus lost trigger state");

	// RULE_08: no sample off boundary
	irq_sample_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		irq_taken |-> $past(instr_done))
		else $error("interrupt taken without instruction boundary");

	// RULE_04: alternate space only in emulator mode
	alt_space_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		alt_space_select |-> emu_now && $past(alt_space_enable))
		else $error("alternate space outside emulator mode");

	// RULE_01: halt response raises halt
	halt_resp_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		(brk_trigger && trigger_response == RESP_HALT) |=> halted_background_debug)
		else $error("halt response did not halt");

	// RULE_10: only the captured bit
	frame_only_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		frame_write |-> (exc_frame_word & 32'hFFFD_FFFF) == 32'h0000_0000)
		else $error("frame word has bits beside the captured flag");

	// RULE_12: resume holds debug code
	resume_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_12
		rte_resume |=> (processor_status_code == STATUS_DEBUG_INT) [*3])
		else $error("resume did not hold debug status code");

	// RULE_09: exception leaves alternate space
	exc_leave_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
		take_any_exc |=> !alt_space_select)
		else $error("alternate space kept after exception");

	// RULE_05: no mask pulse with debug
	debug_mask_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		debug_int_taken |-> !mask_update)
		else $error("mask update with debug interrupt");

	// RULE_03: pending debug wins boundary
	debug_first_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		(instr_done && !rte_exec && dbg_pend_q && !emu_now) |=> debug_int_taken && !frame_write)
		else $error("debug request lost its boundary");

endmodule
`default_nettype wire

// ### tb/status_watch.sv
`timescale 1ns/100ps
`default_nettype none
module status_watch (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] processor_status_code,
	output var  logic [7:0] run_count,
	output var  logic [7:0] last_len
);
	logic [7:0] len_q;

	//==============================================================
	// Debug status code watch, entry and resume runs
	// Measures each run of the debug code; a run ends on any other code
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			len_q     <= 8'h00;
			run_count <= 8'h00;
			last_len  <= 8'h00;
		end else if (processor_status_code == 4'hD) begin
			len_q <= len_q + 8'h01;
		end else if (len_q != 8'h00) begin
			last_len  <= len_q;
			run_count <= run_count + 8'h01;
			len_q     <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### tb/debug_interrupt_emulator_mode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module debug_interrupt_emulator_mode_tb_top;
	import debug_emu_pkg::*;
	logic        clk, rst_b, brk_trigger, alt_space_enable, instr_done, exc_req, rte_exec, halt_release;
	logic [3:0]  brk_trigger_state, core_status_code, processor_status_code, processor_status_debug_bus;
	resp_type    trigger_response;
	logic [2:0]  irq_level_pin, mask_level, irq_taken_level;
	logic [31:0] rte_frame_word, exc_frame_word;
	logic        halted_background_debug, debug_int_taken, irq_taken, mask_update, frame_write, alt_space_select;
	logic [7:0]  run_count, last_len;
	int          fail_count, n_tests;
	logic        dbg, irq, fw, mu;

	debug_interrupt_emulator_mode dut (.clk(clk), .rst_b(rst_b), .brk_trigger(brk_trigger),
		.brk_trigger_state(brk_trigger_state), .trigger_response(trigger_response),
		.alt_space_enable(alt_space_enable), .irq_level_pin(irq_level_pin), .mask_level(mask_level),
		.instr_done(instr_done), .exc_req(exc_req), .rte_exec(rte_exec), .rte_frame_word(rte_frame_word),
		.core_status_code(core_status_code), .halt_release(halt_release),
		.processor_status_code(processor_status_code), .processor_status_debug_bus(processor_status_debug_bus),
		.halted_background_debug(halted_background_debug), .debug_int_taken(debug_int_taken),
		.irq_taken(irq_taken), .irq_taken_level(irq_taken_level), .mask_update(mask_update),
		.frame_write(frame_write), .exc_frame_word(exc_frame_word), .alt_space_select(alt_space_select));

	status_watch watch (.clk(clk), .rst_b(rst_b), .processor_status_code(processor_status_code),
		.run_count(run_count), .last_len(last_len));

	//==============================================================
	// Clock and shared tasks
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One instruction boundary; window wide enough for a registered pulse
	task automatic step();
		{dbg, irq, fw, mu} = 4'h0;
		@(posedge clk) instr_done <= 1'b1;
		@(posedge clk) instr_done <= 1'b0;
		repeat (3) begin
			@(negedge clk);
			{dbg, irq, fw, mu} = {dbg, irq, fw, mu} | {debug_int_taken, irq_taken, frame_write, mask_update};
		end
	endtask

	task automatic trig(input resp_type r);
		@(posedge clk) begin
			trigger_response <= r;
			brk_trigger      <= 1'b1;
		end
		@(posedge clk) brk_trigger <= 1'b0;
	endtask

	task automatic ret(input logic [31:0] w);
		@(posedge clk) begin
			rte_exec       <= 1'b1;
			rte_frame_word <= w;
		end
		@(posedge clk) rte_exec <= 1'b0;
		repeat (6) @(negedge clk);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	//==============================================================
	// Scenarios
	task automatic sc_bus_halt();
		@(posedge clk) brk_trigger_state <= 4'hA;
		@(posedge clk);
		@(negedge clk);
		check(processor_status_debug_bus, 4'hA);
		trig(RESP_HALT);
		@(negedge clk);
		check(halted_background_debug, 1'b1);
		@(posedge clk) halt_release <= 1'b1;
		@(posedge clk) halt_release <= 1'b0;
		@(negedge clk);
		check(halted_background_debug, 1'b0);
	endtask

	task automatic sc_show();
		trig(RESP_SHOW_ONLY);
		step();
		check({dbg, irq, halted_background_debug}, 3'h0);
		trig(RESP_SPARE);
		step();
		check({dbg, irq, halted_background_debug}, 3'h0);
	endtask

	// Debug request raced against the top normal level
	task automatic sc_debug();
		@(posedge clk) begin
			irq_level_pin <= 3'h7;
			mask_level    <= 3'h0;
		end
		trig(RESP_DEBUG_INT);
		step();
		check({dbg, irq}, 2'b10);
		check({mu, fw}, 2'b00);
		repeat (4) @(negedge clk);
		check(last_len, DEBUG_STATUS_CYCLES);
		check(run_count, 8'h01);
		check(alt_space_select, 1'b1);
	endtask

	task automatic sc_nested();
		step();
		check({irq, fw, mu}, 3'b111);
		check(exc_frame_word, 32'h0002_0000);
		check(irq_taken_level, 3'h7);
		check(alt_space_select, 1'b0);
		@(posedge clk) begin
			irq_level_pin <= 3'h3;
			mask_level    <= 3'h5;
		end
		repeat (3) @(posedge clk);
		step();
		check({irq, fw}, 2'b00);
		@(posedge clk) exc_req <= 1'b1;
		step();
		check(fw, 1'b1);
		check(exc_frame_word, 32'h0000_0000);
		@(posedge clk) exc_req <= 1'b0;
		ret(32'h0000_0000);
		check(alt_space_select, 1'b0);
		check(run_count, 8'h01);
		ret(32'h0002_0000);
		check(alt_space_select, 1'b1);
		check(run_count, 8'h02);
		check(last_len, DEBUG_STATUS_CYCLES);
	endtask

	// Second level of nesting still restores the debug routine
	task automatic sc_deep();
		@(posedge clk) exc_req <= 1'b1;
		step();
		check(exc_frame_word, 32'h0002_0000);
		step();
		check(exc_frame_word, 32'h0000_0000);
		@(posedge clk) exc_req <= 1'b0;
		ret(32'h0000_0000);
		ret(32'h0002_0000);
		check(alt_space_select, 1'b1);
		check(run_count, 8'h03);
		check(processor_status_code, 4'h1);
		@(posedge clk) alt_space_enable <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check(alt_space_select, 1'b0);
		@(posedge clk) alt_space_enable <= 1'b1;
	endtask

	//==============================================================
	// Main sequence
	initial begin
		fail_count = 0;
		n_tests = 0;
		rst_b = 1'b0;
		{brk_trigger, instr_done, exc_req, rte_exec, halt_release} = 5'h00;
		alt_space_enable = 1'b1;
		brk_trigger_state = 4'h0;
		core_status_code = 4'h1;
		trigger_response = RESP_SHOW_ONLY;
		irq_level_pin = 3'h0;
		mask_level = 3'h0;
		rte_frame_word = 32'h0000_0000;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		check({halted_background_debug, alt_space_select, debug_int_taken}, 3'h0);
		sc_bus_halt();
		sc_show();
		sc_debug();
		sc_nested();
		sc_deep();
		print_verdict();
	end
endmodule
`default_nettype wire
